// ---- verilog/muxed_bus_burst_wait_recovery.sv ----
// multiplexed address/data bus sequencer: bursts, wait and recovery states
`timescale 1ns/1ps

// How it works
// (RULE1) 16-bit bursts start on A2:1 or A1 zero
// (RULE2) 8-bit bursts start on A1:0 or A0 zero
// (RULE3) no burst crosses a 16-byte boundary
// (RULE4) ready low ends transfer, high adds wait
// (RULE5) outside logic drives ready per needed clock
// (RULE6) burst loops wait/data until all transfers done
// (RULE7) one recovery state after last transfer
// (RULE8) recovery repeats while ready/recover samples low
// (RULE9) outside logic eventually ends recovery
// (RULE10) strobe opens address, last-transfer closes at recovery
// (RULE11) cache hits make no pin activity
// (RULE12) recovery floats bus after read, holds after write
// (RULE13) recovery drives strobes inactive, byte enables high
// (RULE14) recovery freezes address bits, width, direction pins
// (RULE15) idle after write keeps write data driven
// (RULE16) idle after read drives address, word, size
// (RULE17) cancelled request may leave AD1:0 undefined
// (RULE18) unaligned requests split into aligned accesses
// (RULE19) natural boundaries 1,2,4,8,16 by data size
// (RULE20) optional unaligned fault after the access
// (RULE21) unaligned store: single, pair bursts, single
// (RULE22) 32-bit bursts start on A3:2 or A2 zero
// (RULE23) at most four transfers per burst
// (RULE24) address, wait/data, recovery, then idle or address
module muxed_bus_burst_wait_recovery (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // core request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic req_code,
  input wire logic req_cache_hit,
  input wire logic [31:0] req_addr,
  input wire logic [4:0] req_bytes,
  input wire logic [127:0] req_wdata,
  input wire logic [1:0] region_width,
  input wire logic fault_on_unaligned,
  // core answer
  output logic req_ready,
  output logic req_done,
  output logic [127:0] req_rdata,
  output logic unaligned_fault,
  // bus pins
  input wire logic [31:0] muxed_addr_data_in,
  output logic [31:0] muxed_addr_data_out,
  output logic muxed_addr_data_oe_n,
  output logic ale,
  output logic address_strobe_n,
  output logic burst_last_n,
  output logic transceiver_enable_n,
  output logic [3:0] byte_enables_n,
  output logic [1:0] word_address_bits,
  output logic [1:0] width_halt_outputs,
  output logic data_code,
  output logic write_read,
  output logic transceiver_direction,
  input wire logic ready_recover_n
);

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // byte enables or low address lines for one transfer
  function automatic logic [3:0] be_decode(input logic [1:0] w, input logic [1:0] a,
                                           input logic [2:0] s);
    logic [7:0] mask;
    mask = 8'h0;
    if (w == mbus_pkg::WIDTH_32) begin
      mask = ((s == 3'h4) ? 8'h0f : (s == 3'h2) ? 8'h03 : 8'h01) << a;
      be_decode = ~mask[3:0];
    end else if (w == mbus_pkg::WIDTH_16) begin
      be_decode = {(s == 3'h1) && !a[0], 1'h1, a[1], (s == 3'h1) && a[0]};
    end else begin
      be_decode = {2'h3, a};
    end
  endfunction

  // natural boundary mask by request size: 1,2,4,8,16 bytes
  function automatic logic [3:0] nat_mask(input logic [4:0] n);
    case (n) // RULE19
      5'h02: nat_mask = 4'h1;
      5'h04: nat_mask = 4'h3;
      5'h08: nat_mask = 4'h7;
      5'h0c, 5'h10: nat_mask = 4'hf;
      default: nat_mask = 4'h0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state and working registers
  // ----------------------------------------------------------------
  mbus_pkg::bus_state_t state;
  mbus_pkg::bus_state_t next_state;
  logic [1:0] age;
  logic [31:0] xaddr;
  logic [31:0] chunk_addr;
  logic [1:0] size_code;
  logic [4:0] remain;
  logic [4:0] off;
  logic [2:0] left;
  logic [2:0] step;
  logic [1:0] width;
  logic [127:0] wbuf;
  logic wr;
  logic code;
  logic unal;
  logic fault_en;
  logic rr_meta;
  logic rr_sync;
  logic [31:0] ad_meta;
  logic [31:0] ad_sync;
  logic [127:0] next_rdata;

  split_if sp ();

  access_splitter u_split (
    .sp(sp)
  );

  // ----------------------------------------------------------------
  // request take and splitter feed
  // ----------------------------------------------------------------
  wire in_idle = (state == mbus_pkg::idle_state);
  wire take = req_valid && req_ready;
  wire take_bus = take && !req_cache_hit; // RULE11
  assign sp.addr = in_idle ? req_addr : xaddr;
  assign sp.remain = in_idle ? req_bytes : remain;
  assign sp.width = in_idle ? region_width : width;
  wire cur_wr = in_idle ? req_write : wr;
  wire cur_code = in_idle ? req_code : code;

  // ----------------------------------------------------------------
  // ready/recover sampling, valid once the pipe holds this state
  // ----------------------------------------------------------------
  wire sample_ok = (age == mbus_pkg::SAMPLE_AGE);
  wire xfer_done = (state == mbus_pkg::wait_or_data_state) && sample_ok
                   && !rr_sync; // RULE4
  wire rec_end = (state == mbus_pkg::recovery_state) && sample_ok
                 && rr_sync; // RULE8 RULE9
  wire last_xfer = (left == 3'h1);
  wire more = (remain != 5'h0);

  // next state sequence
  always_comb begin
    next_state = state;
    case (state)
      mbus_pkg::idle_state: begin
        if (take_bus) begin
          next_state = mbus_pkg::address_state; // RULE24
        end
      end
      mbus_pkg::address_state: begin
        next_state = mbus_pkg::wait_or_data_state;
      end
      mbus_pkg::wait_or_data_state: begin
        if (xfer_done && last_xfer) begin
          next_state = mbus_pkg::recovery_state; // RULE7
        end
      end
      mbus_pkg::recovery_state: begin
        if (rec_end) begin
          next_state = more ? mbus_pkg::address_state : mbus_pkg::idle_state; // RULE24
        end
      end
      default: begin
        next_state = mbus_pkg::idle_state;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // write data placement and read data gathering
  // ----------------------------------------------------------------
  wire in_wait = (state == mbus_pkg::wait_or_data_state);
  wire [31:0] nx_addr = xaddr + {29'h0, step};
  wire [4:0] nx_off = off + {2'h0, step};
  wire [31:0] d_addr = in_wait ? nx_addr : xaddr;
  wire [4:0] d_off = in_wait ? nx_off : off;
  wire [1:0] lane = (width == mbus_pkg::WIDTH_32) ? d_addr[1:0] :
                    (width == mbus_pkg::WIDTH_16) ? {1'h0, d_addr[0]} : 2'h0;
  wire [1:0] rlane = (width == mbus_pkg::WIDTH_32) ? xaddr[1:0] :
                     (width == mbus_pkg::WIDTH_16) ? {1'h0, xaddr[0]} : 2'h0;
  wire [159:0] wpad = {32'h0, wbuf};
  wire [31:0] chunk = wpad[{d_off, 3'h0} +: 32];
  // narrow data is copied onto every unused lane
  wire [31:0] rep = (step == 3'h1) ? {4{chunk[7:0]}} :
                    (step == 3'h2) ? {2{chunk[15:0]}} : chunk;
  wire [63:0] rot = {rep, rep} << {lane, 3'h0};
  wire [31:0] wd = rot[63:32];
  wire [63:0] back = {ad_sync, ad_sync} >> {rlane, 3'h0};
  wire [31:0] rbytes = back[31:0];

  // drop received bytes into their request positions
  always_comb begin
    logic [4:0] k;
    k = 5'h0;
    next_rdata = req_rdata;
    for (int i = 0; i < 16; i++) begin
      k = 5'(i) - off;
      if (k < {2'h0, step}) begin
        next_rdata[i*8 +: 8] = rbytes[{k[1:0], 3'h0} +: 8];
      end
    end
  end

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rr_meta <= 1'h1;
      rr_sync <= 1'h1;
      ad_meta <= 32'h0;
      ad_sync <= 32'h0;
    end else begin
      rr_meta <= ready_recover_n;
      rr_sync <= rr_meta;
      ad_meta <= muxed_addr_data_in;
      ad_sync <= ad_meta;
    end
  end

  // state and sample age
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= mbus_pkg::idle_state;
      age <= 2'h0;
    end else begin
      state <= next_state;
      if (next_state != state || xfer_done) begin
        age <= 2'h0;
      end else if (!sample_ok) begin
        age <= age + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // request bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      xaddr <= 32'h0;
      chunk_addr <= 32'h0;
      size_code <= 2'h0;
      remain <= 5'h0;
      off <= 5'h0;
      left <= 3'h0;
      step <= 3'h0;
      width <= mbus_pkg::WIDTH_8;
      wbuf <= 128'h0;
      wr <= 1'h0;
      code <= 1'h0;
      unal <= 1'h0;
      fault_en <= 1'h0;
    end else begin
      if (take_bus) begin
        xaddr <= req_addr;
        remain <= req_bytes;
        off <= 5'h0;
        width <= region_width;
        wbuf <= req_wdata;
        wr <= req_write;
        code <= req_code;
        unal <= |(req_addr[3:0] & nat_mask(req_bytes)); // RULE19
        fault_en <= fault_on_unaligned;
      end
      if (next_state == mbus_pkg::address_state) begin
        chunk_addr <= sp.addr;
        left <= sp.count;
        step <= sp.step;
        size_code <= 2'(sp.count - 3'h1);
      end else if (xfer_done) begin
        xaddr <= nx_addr; // RULE6
        off <= nx_off;
        remain <= remain - {2'h0, step};
        left <= left - 3'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // core answer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      req_ready <= 1'h0;
      req_done <= 1'h0;
      req_rdata <= 128'h0;
      unaligned_fault <= 1'h0;
    end else begin
      req_ready <= (next_state == mbus_pkg::idle_state) && !take_bus;
      req_done <= (take && req_cache_hit) || (rec_end && !more);
      unaligned_fault <= rec_end && !more && unal && fault_en; // RULE20
      if (xfer_done && !wr) begin
        req_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus pins, set on state transitions and between the transfers of a burst
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      muxed_addr_data_out <= 32'h0;
      muxed_addr_data_oe_n <= 1'h1;
      ale <= 1'h0;
      address_strobe_n <= 1'h1;
      burst_last_n <= 1'h1;
      transceiver_enable_n <= 1'h1;
      byte_enables_n <= mbus_pkg::BE_INACTIVE;
      word_address_bits <= 2'h0;
      width_halt_outputs <= mbus_pkg::WIDTH_8;
      data_code <= 1'h0;
      write_read <= 1'h0;
      transceiver_direction <= 1'h0;
    end else if (next_state == mbus_pkg::address_state) begin
      // address state: latch and strobe the new access
      muxed_addr_data_out <= {sp.addr[31:2], 2'(sp.count - 3'h1)};
      muxed_addr_data_oe_n <= 1'h0;
      ale <= 1'h1;
      address_strobe_n <= 1'h0; // RULE10
      byte_enables_n <= be_decode(sp.width, sp.addr[1:0], sp.step);
      word_address_bits <= sp.addr[3:2];
      width_halt_outputs <= sp.width;
      data_code <= !cur_code;
      write_read <= cur_wr;
      transceiver_direction <= cur_wr;
    end else if (state == mbus_pkg::address_state) begin
      // first wait/data state
      ale <= 1'h0;
      address_strobe_n <= 1'h1;
      transceiver_enable_n <= 1'h0;
      burst_last_n <= !last_xfer;
      muxed_addr_data_out <= wr ? wd : muxed_addr_data_out;
      muxed_addr_data_oe_n <= !wr;
    end else if (xfer_done && !last_xfer) begin
      // next transfer of the burst: address lines step on
      byte_enables_n <= be_decode(width, nx_addr[1:0], step);
      word_address_bits <= nx_addr[3:2];
      burst_last_n <= (left != 3'h2);
      muxed_addr_data_out <= wr ? wd : muxed_addr_data_out;
    end else if (next_state == mbus_pkg::recovery_state && in_wait) begin
      // recovery: strobes off, enables high, the rest frozen
      burst_last_n <= 1'h1; // RULE10 RULE13
      transceiver_enable_n <= 1'h1; // RULE13
      byte_enables_n <= mbus_pkg::BE_INACTIVE; // RULE13
      muxed_addr_data_oe_n <= !wr; // RULE12 RULE14
    end else if (next_state == mbus_pkg::idle_state && rec_end && !wr) begin
      // idle after a read: park the last address and size
      muxed_addr_data_out <= {chunk_addr[31:4], word_address_bits, size_code}; // RULE16
      muxed_addr_data_oe_n <= 1'h0; // RULE16 RULE17
    end
    // idle after a write keeps the write data on the lines
  end // RULE15

endmodule // muxed_bus_burst_wait_recovery

// ---- verilog/mbus_pkg.sv ----
// constants and types shared by the bus sequencer and the access splitter
package mbus_pkg;

  // ----------------------------------------------------------------
  // region width codes, driven on the width/halt outputs
  // ----------------------------------------------------------------
  localparam logic [1:0] WIDTH_8 = 2'h0;
  localparam logic [1:0] WIDTH_16 = 2'h1;
  localparam logic [1:0] WIDTH_32 = 2'h2;

  // ----------------------------------------------------------------
  // pin levels and counts
  // ----------------------------------------------------------------
  localparam logic [3:0] BE_INACTIVE = 4'hf;
  localparam logic [1:0] SAMPLE_AGE = 2'h2;
  localparam logic [2:0] MAX_XFERS = 3'h4;
  localparam logic [4:0] TRIPLE_BYTES = 5'h0c;
  localparam logic [4:0] BURST_BOUNDARY = 5'h10;

  // ----------------------------------------------------------------
  // bus states, gray coded along idle, address, wait/data, recovery
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    idle_state = 2'h0,
    address_state = 2'h1,
    wait_or_data_state = 2'h3,
    recovery_state = 2'h2
  } bus_state_t;

endpackage

// ---- verilog/split_if.sv ----
// carrier between the bus sequencer and the access splitter
`timescale 1ns/1ps
interface split_if;
  logic [31:0] addr;
  logic [4:0] remain;
  logic [1:0] width;
  logic [2:0] count;
  logic [2:0] step;
  modport asker (output addr, output remain, output width, input count, input step);
  modport solver (input addr, input remain, input width, output count, output step);
endinterface

// ---- verilog/access_splitter.sv ----
// picks the next aligned bus access for what remains of a request
`timescale 1ns/1ps
module access_splitter (
  // request remainder in, next access out
  split_if.solver sp
);

  // ----------------------------------------------------------------
  // alignment of the current address against the region width
  // ----------------------------------------------------------------
  wire is32 = (sp.width == mbus_pkg::WIDTH_32);
  wire is16 = (sp.width == mbus_pkg::WIDTH_16);
  wire [2:0] unit = is32 ? 3'h4 : (is16 ? 3'h2 : 3'h1);
  wire [4:0] unit4 = {unit, 2'h0};
  wire [4:0] unit2 = {1'h0, unit, 1'h0};
  wire unit_ok = (is32 ? (sp.addr[1:0] == 2'h0) : (is16 ? !sp.addr[0] : 1'h1))
                 && (sp.remain >= {2'h0, unit});
  // burst starts: quad on 4-unit, pair on 2-unit boundaries
  wire al4 = is32 ? (sp.addr[3:0] == 4'h0) : // RULE22
             (is16 ? (sp.addr[2:0] == 3'h0) : (sp.addr[1:0] == 2'h0)); // RULE1 RULE2
  wire al2 = is32 ? (sp.addr[2:0] == 3'h0) :
             (is16 ? (sp.addr[1:0] == 2'h0) : !sp.addr[0]); // RULE1 RULE2

  // ----------------------------------------------------------------
  // transfer count and bytes per transfer
  // ----------------------------------------------------------------
  // a burst never exceeds four transfers nor leaves its aligned 16 bytes
  wire [2:0] burst_n = (al4 && sp.remain >= unit4) ? mbus_pkg::MAX_XFERS : // RULE23 RULE3
                       (is32 && al4 && sp.remain >= mbus_pkg::TRIPLE_BYTES) ? 3'h3 :
                       (al2 && sp.remain >= unit2) ? 3'h2 : 3'h1;
  // misaligned head or short tail falls back to a byte or short word
  wire [2:0] sub_step = (sp.addr[0] || sp.remain == 5'h1) ? 3'h1 : 3'h2; // RULE18 RULE21
  assign sp.count = unit_ok ? burst_n : 3'h1;
  assign sp.step = unit_ok ? unit : sub_step;

endmodule // access_splitter

// ---- bench/mbus_sva.sv ----
// assertions on the pins and core handshake of the bus sequencer
`timescale 1ns/1ps
module mbus_sva (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // core handshake
  input wire logic req_valid,
  input wire logic req_cache_hit,
  input wire logic req_ready,
  input wire logic req_done,
  // bus pins
  input wire logic [31:0] muxed_addr_data_out,
  input wire logic muxed_addr_data_oe_n,
  input wire logic ale,
  input wire logic address_strobe_n,
  input wire logic burst_last_n,
  input wire logic transceiver_enable_n,
  input wire logic [3:0] byte_enables_n,
  input wire logic [1:0] word_address_bits,
  input wire logic [1:0] width_halt_outputs,
  input wire logic data_code,
  input wire logic write_read,
  input wire logic transceiver_direction,
  input wire logic ready_recover_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  // ----------------
  // bus state checks
  // ----------------
  a_strobe_with_ale: assert property ($fell(address_strobe_n) |-> ale)
    else $error("address strobe without latch enable");
  a_data_follows_addr: assert property ($fell(address_strobe_n) |->
    ##[1:3] (address_strobe_n && !transceiver_enable_n))
    else $error("no wait or data state after address");
  a_ready_ends_xfer: assert property ($rose(burst_last_n) |-> !$past(ready_recover_n, 3))
    else $error("transfer ended without ready low");
  a_rcv_pins_idle: assert property ($rose(burst_last_n) |-> byte_enables_n == 4'hf &&
    transceiver_enable_n && !ale && address_strobe_n)
    else $error("recovery controls not inactive");
  a_rcv_float_read: assert property ($rose(burst_last_n) && !write_read |->
    muxed_addr_data_oe_n)
    else $error("bus driven in recovery after read");
  a_rcv_hold_write: assert property ($rose(burst_last_n) && write_read |->
    !muxed_addr_data_oe_n && $stable(muxed_addr_data_out))
    else $error("write data not held in recovery");
  a_rcv_freeze: assert property ($rose(burst_last_n) |-> $stable({word_address_bits,
    width_halt_outputs, data_code, write_read, transceiver_direction}))
    else $error("frozen outputs moved in recovery");
  a_rcv_min_len: assert property ($rose(burst_last_n) |-> address_strobe_n [*3])
    else $error("recovery shorter than one state");
  a_hit_quiet: assert property (req_valid && req_ready && req_cache_hit |=>
    req_done && address_strobe_n && $stable(muxed_addr_data_out))
    else $error("cache hit touched the bus");
  a_busy_after_take: assert property (req_valid && req_ready && !req_cache_hit |=>
    !req_ready [*3])
    else $error("ready while a bus request runs");
  // main scenarios
  c_write_rcv: cover property ($rose(burst_last_n) && write_read);
  c_read_rcv: cover property ($rose(burst_last_n) && !write_read);
  c_hit: cover property (req_valid && req_ready && req_cache_hit);
endmodule // mbus_sva

bind muxed_bus_burst_wait_recovery mbus_sva chk (.mclk, .rstn, .req_valid, .req_cache_hit,
  .req_ready, .req_done, .muxed_addr_data_out, .muxed_addr_data_oe_n, .ale,
  .address_strobe_n, .burst_last_n, .transceiver_enable_n, .byte_enables_n,
  .word_address_bits, .width_halt_outputs, .data_code, .write_read,
  .transceiver_direction, .ready_recover_n);

// ---- bench/ext_mem_model.sv ----
// external memory with programmable ready and recovery pacing
`timescale 1ns/1ps
module ext_mem_model (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // bus pins from the device
  input wire logic address_strobe_n,
  input wire logic transceiver_enable_n,
  input wire logic write_read,
  input wire logic [1:0] word_address_bits,
  input wire logic [31:0] muxed_addr_data_out,
  // pacing set by the bench
  input wire logic [3:0] wait_n,
  input wire logic [3:0] rec_extra,
  // answers
  output logic ready_recover_n,
  output logic [31:0] muxed_addr_data_in
);
  logic [31:0] latched;
  logic [3:0] cnt;
  logic prev_en;
  logic [3:0] age;
  logic [31:0] word;
  // age of the current enable phase, word stored at the bus address
  assign age = (transceiver_enable_n != prev_en) ? 4'h0 : cnt;
  assign word = {latched[31:4], word_address_bits, 2'h0} ^ 32'hc3c3_3c3c;
  // not ready for wait_n cycles, then ready in data phase
  assign ready_recover_n = !transceiver_enable_n ? (age < wait_n) :
    (age >= rec_extra);
  // released lines show the inverse of the data
  assign muxed_addr_data_in = (!transceiver_enable_n && !write_read) ? word : ~word;
  // latch address, count cycles of each phase
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      latched <= 32'h0;
      cnt <= 4'h0;
      prev_en <= 1'b1;
    end else begin
      if (!address_strobe_n) latched <= muxed_addr_data_out;
      cnt <= age + {3'h0, age != 4'hf};
      prev_en <= transceiver_enable_n;
    end
  end
endmodule // ext_mem_model

// ---- bench/test_muxed_bus_burst_wait_recovery.sv ----
// self-checking bench for the bus sequencer against an external memory model
`timescale 1ns/1ps
module test_muxed_bus_burst_wait_recovery;
  logic mclk, rstn, req_valid, req_write, req_code, req_cache_hit, fault_on_unaligned;
  logic [31:0] req_addr, muxed_addr_data_in, muxed_addr_data_out;
  logic [4:0] req_bytes;
  logic [127:0] req_wdata, req_rdata;
  logic [1:0] region_width, word_address_bits, width_halt_outputs;
  logic req_ready, req_done, unaligned_fault, muxed_addr_data_oe_n, ale, address_strobe_n;
  logic burst_last_n, transceiver_enable_n, data_code, write_read, transceiver_direction;
  logic ready_recover_n;
  logic [3:0] byte_enables_n, wait_n, rec_extra;
  logic [31:0] seen[$];
  int fails = 0;
  int check_count = 0;
  int base;
  int cyc;
  // ----------------
  // design and far side
  // ----------------
  muxed_bus_burst_wait_recovery uut (.mclk, .rstn, .req_valid, .req_write, .req_code,
    .req_cache_hit, .req_addr, .req_bytes, .req_wdata, .region_width, .fault_on_unaligned,
    .req_ready, .req_done, .req_rdata, .unaligned_fault, .muxed_addr_data_in,
    .muxed_addr_data_out, .muxed_addr_data_oe_n, .ale, .address_strobe_n, .burst_last_n,
    .transceiver_enable_n, .byte_enables_n, .word_address_bits, .width_halt_outputs,
    .data_code, .write_read, .transceiver_direction, .ready_recover_n);
  ext_mem_model mem (.mclk, .rstn, .address_strobe_n, .transceiver_enable_n, .write_read,
    .word_address_bits, .muxed_addr_data_out, .wait_n, .rec_extra, .ready_recover_n,
    .muxed_addr_data_in);
  // ----------------
  // helpers
  // ----------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task test_done;
    if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [1:0] low_lane(input logic [3:0] be);
    return !be[0] ? 2'h0 : !be[1] ? 2'h1 : !be[2] ? 2'h2 : 2'h3;
  endfunction
  // byte address of every address state, by region width
  always @(negedge mclk)
    if (rstn && address_strobe_n === 1'b0)
      seen.push_back(region_width == mbus_pkg::WIDTH_32 ?
        {muxed_addr_data_out[31:2], low_lane(byte_enables_n)} :
        region_width == mbus_pkg::WIDTH_16 ?
        {muxed_addr_data_out[31:2], byte_enables_n[1], 1'b0} :
        {muxed_addr_data_out[31:2], byte_enables_n[1:0]});
  // one request from offer to done, leaves the cycles taken in cyc
  task automatic do_req(input logic wr, input logic hit, input logic [31:0] a,
      input logic [4:0] n, input logic [127:0] wd);
    @(negedge mclk);
    req_write = wr;
    req_cache_hit = hit;
    req_addr = a;
    req_bytes = n;
    req_wdata = wd;
    req_valid = 1'b1;
    seen.delete();
    while (req_ready !== 1'b1) @(negedge mclk);
    @(negedge mclk);
    req_valid = 1'b0;
    cyc = 1;
    while (req_done !== 1'b1 && cyc < 3000) begin
      @(negedge mclk);
      cyc++;
    end
    cmp("req_done", 32'h1, {31'h0, req_done});
  endtask
  task automatic chk_list(input logic [31:0] e0, e1, e2, e3);
    cmp("access_count", 32'h4, seen.size());
    foreach (seen[i]) cmp("access_addr", i == 0 ? e0 : i == 1 ? e1 : i == 2 ? e2 : e3, seen[i]);
  endtask
  // ----------------
  // scenarios
  // ----------------
  task t_quad_read32;
    region_width = mbus_pkg::WIDTH_32;
    do_req(1'b0, 1'b0, 32'h30, 5'h10, 128'h0);
    base = cyc;
    cmp("bursts", 32'h1, seen.size());
    cmp("burst_addr", 32'h30, seen[0]);
    for (int i = 0; i < 4; i++)
      cmp("rdata", (32'h30 + 32'(4 * i)) ^ 32'hc3c3_3c3c, req_rdata[32 * i +: 32]);
    cmp("no_fault", 32'h0, {31'h0, unaligned_fault});
    cmp("idle_addr", 32'hf, {2'h0, muxed_addr_data_out[31:2]});
    cmp("idle_oe_n", 32'h0, {31'h0, muxed_addr_data_oe_n});
    cmp("dir_in", 32'h0, {31'h0, transceiver_direction});
  endtask
  task t_hit;
    do_req(1'b0, 1'b1, 32'h50, 5'h4, 128'h0);
    cmp("hit_accesses", 32'h0, seen.size());
    cmp("hit_cycles", 32'h1, cyc);
  endtask
  task t_write32;
    do_req(1'b1, 1'b0, 32'h40, 5'h4, 128'ha5a5_1234);
    cmp("idle_wdata", 32'ha5a5_1234, muxed_addr_data_out);
    cmp("dir_out", 32'h1, {31'h0, transceiver_direction});
    cmp("code_pin_wr", 32'h1, {31'h0, data_code});
  endtask
  task t_store16;
    region_width = mbus_pkg::WIDTH_16;
    fault_on_unaligned = 1'b0;
    do_req(1'b1, 1'b0, 32'h0a, 5'h0c, 128'h1111_2222_3333_4444_5555_6666);
    chk_list(32'h0a, 32'h0c, 32'h10, 32'h14);
    cmp("fault_off", 32'h0, {31'h0, unaligned_fault});
    fault_on_unaligned = 1'b1;
  endtask
  task t_load8;
    region_width = mbus_pkg::WIDTH_8;
    req_code = 1'b1;
    do_req(1'b0, 1'b0, 32'h20, 5'h10, 128'h0);
    chk_list(32'h20, 32'h24, 32'h28, 32'h2c);
    cmp("code_pin", 32'h0, {31'h0, data_code});
    req_code = 1'b0;
  endtask
  task t_unaligned32;
    region_width = mbus_pkg::WIDTH_32;
    do_req(1'b0, 1'b0, 32'h21, 5'h8, 128'h0);
    chk_list(32'h21, 32'h22, 32'h24, 32'h28);
    cmp("fault", 32'h1, {31'h0, unaligned_fault});
  endtask
  task t_slow;
    wait_n = 4'h5;
    rec_extra = 4'h4;
    do_req(1'b0, 1'b0, 32'h30, 5'h10, 128'h0);
    cmp("slow_longer", 32'h1, {31'h0, cyc >= base + 8});
    cmp("slow_rdata", 32'h30 ^ 32'hc3c3_3c3c, req_rdata[31:0]);
    wait_n = 4'h0;
    rec_extra = 4'h0;
  endtask
  // ----------------
  // main sequence and watchdog
  // ----------------
  initial begin
    {rstn, req_valid, req_write, req_code, req_cache_hit} = 5'h0;
    fault_on_unaligned = 1'b1;
    req_addr = 32'h0;
    req_bytes = 5'h4;
    req_wdata = 128'h0;
    region_width = mbus_pkg::WIDTH_32;
    wait_n = 4'h0;
    rec_extra = 4'h0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    rstn = 1'b1;
    repeat (2) @(negedge mclk);
    t_quad_read32();
    t_hit();
    t_write32();
    t_store16();
    t_load8();
    t_unaligned32();
    t_slow();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    test_done();
  end
endmodule // test_muxed_bus_burst_wait_recovery
